//--- shared/ptp1_regs.vh
// Register indices, reset values, field positions and codes of the port 1 timing registers
`ifndef PTP1_REGS_VH
`define PTP1_REGS_VH

// ==========================================================================
// Register indices (byte address = index * 4)
`define PTP1_IDX_RX_LAT     14'h0640
`define PTP1_IDX_TX_LAT     14'h0642
`define PTP1_IDX_ASYM       14'h0644
`define PTP1_IDX_LINK_DLY   14'h0646
`define PTP1_IDX_DREQ_LO    14'h0648
`define PTP1_IDX_DREQ_HI    14'h064A
`define PTP1_IDX_SYNC_LO    14'h064C
`define PTP1_IDX_SYNC_HI    14'h064E
`define PTP1_IDX_PRESP_LO   14'h0650
`define PTP1_IDX_PRESP_HI   14'h0652

// ==========================================================================
// Reset values
`define PTP1_RST_RX_LAT     16'h019F
`define PTP1_RST_TX_LAT     16'h002D
`define PTP1_RST_ZERO       16'h0000

// ==========================================================================
// Field positions
`define PTP1_ASYM_SIGN      15
`define PTP1_ASYM_MAG_MSB   14
`define PTP1_HI_SEC_MSB     15
`define PTP1_HI_SEC_LSB     14
`define PTP1_HI_NS_MSB      13
`define PTP1_CORR_FRAC      16

// ==========================================================================
// Message types and bus responses
`define PTP1_MSG_SYNC       4'h0
`define PTP1_MSG_DLY_REQ    4'h1
`define PTP1_MSG_PDLY_REQ   4'h2
`define PTP1_MSG_PDLY_RESP  4'h3
`define PTP1_RESP_OKAY      2'h0
`define PTP1_RESP_SLVERR    2'h2

`endif

//--- design/ptp1_stamp_pair.v
// One egress timestamp register pair, low and high word
`default_nettype none
`include "ptp1_regs.vh"

module ptp1_stamp_pair (
    input  wire        aclk,
    input  wire        aresetn,
    input  wire        cap,
    input  wire [1:0]  sec,
    input  wire [29:0] ns,
    input  wire        we_lo,
    input  wire        we_hi,
    input  wire [15:0] wdata,
    input  wire [1:0]  wstrb,
    output reg  [15:0] stamp_lo_q,
    output reg  [15:0] stamp_hi_q
);

    function [15:0] merge16;
        input [15:0] old;
        input [15:0] nw;
        input [1:0]  strb;
        begin
            merge16 = {strb[1] ? nw[15:8] : old[15:8], strb[0] ? nw[7:0] : old[7:0]};
        end
    endfunction

    // ======================================================================
    // Capture beats a same-cycle software write so no stamp is lost
    always @(posedge aclk) begin
        if (!aresetn) begin
            stamp_lo_q <= `PTP1_RST_ZERO;
            stamp_hi_q <= `PTP1_RST_ZERO;
        end else if (cap) begin
            stamp_lo_q <= ns[15:0];
            stamp_hi_q <= {sec[1:0], ns[29:16]};
        end else begin
            if (we_lo)
                stamp_lo_q <= merge16(stamp_lo_q, wdata, wstrb);
            if (we_hi)
                stamp_hi_q <= merge16(stamp_hi_q, wdata, wstrb);
        end
    end

endmodule
`default_nettype wire

//--- design/ptp1_corr_adjust.v
// Asymmetry adjustment of the PTP correction field
`default_nettype none
`include "ptp1_regs.vh"

module ptp1_corr_adjust (
    input  wire        aclk,
    input  wire        aresetn,
    input  wire [15:0] asym,
    input  wire        in_valid,
    input  wire        in_ingress,
    input  wire [3:0]  in_msg_type,
    input  wire [63:0] in_corr,
    output reg         out_valid_q,
    output reg  [63:0] out_corr_q
);

    wire [63:0] mag_scaled;
    wire [63:0] asym_signed;
    wire        do_add;
    wire        do_sub;

    // Magnitude is whole ns; the field carries ns scaled by 2^16
    assign mag_scaled  = {33'h0, asym[`PTP1_ASYM_MAG_MSB:0], 16'h0000};
    assign asym_signed = asym[`PTP1_ASYM_SIGN] ? (64'h0 - mag_scaled) : mag_scaled;
    assign do_add = in_ingress & ((in_msg_type == `PTP1_MSG_SYNC) |
                                  (in_msg_type == `PTP1_MSG_PDLY_RESP));
    assign do_sub = ~in_ingress & ((in_msg_type == `PTP1_MSG_DLY_REQ) |
                                   (in_msg_type == `PTP1_MSG_PDLY_REQ));

    // ======================================================================
    // One cycle latency; other messages pass unchanged
    always @(posedge aclk) begin
        if (!aresetn) begin
            out_valid_q <= 1'b0;
            out_corr_q  <= 64'h0;
        end else begin
            out_valid_q <= in_valid;
            if (in_valid) begin
                if (do_add)
                    out_corr_q <= in_corr + asym_signed;
                else if (do_sub)
                    out_corr_q <= in_corr - asym_signed;
                else
                    out_corr_q <= in_corr;
            end
        end
    end

endmodule
`default_nettype wire

//--- design/ptp1_timing_regs.v
// Port 1 PTP timing register bank with AXI4-Lite slave
`default_nettype none
`include "ptp1_regs.vh"

module ptp1_timing_regs (
    input  wire        aclk,
    input  wire        aresetn,
    // AXI4-Lite write address
    input  wire [15:0] s_axi_awaddr,
    input  wire [2:0]  s_axi_awprot,
    input  wire        s_axi_awvalid,
    output reg         s_axi_awready,
    // AXI4-Lite write data
    input  wire [31:0] s_axi_wdata,
    input  wire [3:0]  s_axi_wstrb,
    input  wire        s_axi_wvalid,
    output reg         s_axi_wready,
    // AXI4-Lite write response
    output reg  [1:0]  s_axi_bresp,
    output reg         s_axi_bvalid,
    input  wire        s_axi_bready,
    // AXI4-Lite read address
    input  wire [15:0] s_axi_araddr,
    input  wire [2:0]  s_axi_arprot,
    input  wire        s_axi_arvalid,
    output reg         s_axi_arready,
    // AXI4-Lite read data
    output reg  [31:0] s_axi_rdata,
    output reg  [1:0]  s_axi_rresp,
    output reg         s_axi_rvalid,
    input  wire        s_axi_rready,
    // Egress timestamp report from the port 1 transmitter
    input  wire        egr_valid,
    input  wire [3:0]  egr_msg_type,
    input  wire [1:0]  egr_sec,
    input  wire [29:0] egr_ns,
    // Correction field path
    input  wire        corr_valid,
    input  wire        corr_ingress,
    input  wire [3:0]  corr_msg_type,
    input  wire [63:0] corr_in,
    output wire        corr_out_valid,
    output wire [63:0] corr_out,
    // Programmed values for the timestamp core
    output reg  [15:0] tx_latency_q,
    output reg  [15:0] rx_latency_q,
    output reg  [15:0] link_delay_q,
    output reg  [15:0] asymmetry_q
);

    // ======================================================================
    // Helper functions
    function mapped;
        input [13:0] idx;
        begin
            case (idx)
                `PTP1_IDX_RX_LAT, `PTP1_IDX_TX_LAT, `PTP1_IDX_ASYM, `PTP1_IDX_LINK_DLY,
                `PTP1_IDX_DREQ_LO, `PTP1_IDX_DREQ_HI, `PTP1_IDX_SYNC_LO, `PTP1_IDX_SYNC_HI,
                `PTP1_IDX_PRESP_LO, `PTP1_IDX_PRESP_HI: mapped = 1'b1;
                default: mapped = 1'b0;
            endcase
        end
    endfunction

    function [15:0] merge16;
        input [15:0] old;
        input [15:0] nw;
        input [1:0]  strb;
        begin
            merge16 = {strb[1] ? nw[15:8] : old[15:8], strb[0] ? nw[7:0] : old[7:0]};
        end
    endfunction

    // ======================================================================
    // Declarations
    reg         aw_full_q;
    reg  [13:0] aw_idx_q;
    reg         w_full_q;
    reg  [15:0] w_data_q;
    reg  [1:0]  w_strb_q;
    wire        do_write;
    wire        wr_ok;
    wire [13:0] ar_idx;
    wire        cap_dreq;
    wire        cap_sync;
    wire        cap_presp;
    wire [15:0] dreq_lo;
    wire [15:0] dreq_hi;
    wire [15:0] sync_lo;
    wire [15:0] sync_hi;
    wire [15:0] presp_lo;
    wire [15:0] presp_hi;
    reg  [15:0] rd_mux;

    // Upper data lanes and protection bits carry nothing for 16-bit registers
    assign ar_idx   = s_axi_araddr[15:2];
    assign do_write = aw_full_q & w_full_q & ~s_axi_bvalid;
    assign wr_ok    = mapped(aw_idx_q);

    // ======================================================================
    // Write channels: address and data taken in either order
    always @(posedge aclk) begin
        if (!aresetn) begin
            aw_full_q     <= 1'b0;
            aw_idx_q      <= 14'h0000;
            w_full_q      <= 1'b0;
            w_data_q      <= 16'h0000;
            w_strb_q      <= 2'h0;
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= `PTP1_RESP_OKAY;
        end else begin
            if (!aw_full_q && !s_axi_bvalid && !s_axi_awready)
                s_axi_awready <= 1'b1;
            if (!w_full_q && !s_axi_bvalid && !s_axi_wready)
                s_axi_wready <= 1'b1;
            if (s_axi_awvalid && s_axi_awready) begin
                aw_full_q     <= 1'b1;
                aw_idx_q      <= s_axi_awaddr[15:2];
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_full_q     <= 1'b1;
                w_data_q     <= s_axi_wdata[15:0];
                w_strb_q     <= s_axi_wstrb[1:0];
                s_axi_wready <= 1'b0;
            end
            if (do_write) begin
                aw_full_q    <= 1'b0;
                w_full_q     <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= wr_ok ? `PTP1_RESP_OKAY : `PTP1_RESP_SLVERR;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // ======================================================================
    // Configuration registers
    always @(posedge aclk) begin
        if (!aresetn) begin
            tx_latency_q <= `PTP1_RST_TX_LAT;
            rx_latency_q <= `PTP1_RST_RX_LAT;
            asymmetry_q  <= `PTP1_RST_ZERO;
            link_delay_q <= `PTP1_RST_ZERO;
        end else if (do_write) begin
            case (aw_idx_q)
                `PTP1_IDX_TX_LAT:   tx_latency_q <= merge16(tx_latency_q, w_data_q, w_strb_q);
                `PTP1_IDX_RX_LAT:   rx_latency_q <= merge16(rx_latency_q, w_data_q, w_strb_q);
                `PTP1_IDX_ASYM:     asymmetry_q  <= merge16(asymmetry_q, w_data_q, w_strb_q);
                `PTP1_IDX_LINK_DLY: link_delay_q <= merge16(link_delay_q, w_data_q, w_strb_q);
                default: ;
            endcase
        end
    end

    // ======================================================================
    // Egress timestamp capture, one pair per message family
    assign cap_dreq  = egr_valid & ((egr_msg_type == `PTP1_MSG_DLY_REQ) |
                                    (egr_msg_type == `PTP1_MSG_PDLY_REQ));
    assign cap_sync  = egr_valid & (egr_msg_type == `PTP1_MSG_SYNC);
    assign cap_presp = egr_valid & (egr_msg_type == `PTP1_MSG_PDLY_RESP);

    ptp1_stamp_pair u_dreq (
        .aclk       (aclk),
        .aresetn    (aresetn),
        .cap        (cap_dreq),
        .sec        (egr_sec),
        .ns         (egr_ns),
        .we_lo      (do_write && aw_idx_q == `PTP1_IDX_DREQ_LO),
        .we_hi      (do_write && aw_idx_q == `PTP1_IDX_DREQ_HI),
        .wdata      (w_data_q),
        .wstrb      (w_strb_q),
        .stamp_lo_q (dreq_lo),
        .stamp_hi_q (dreq_hi)
    );

    ptp1_stamp_pair u_sync (
        .aclk       (aclk),
        .aresetn    (aresetn),
        .cap        (cap_sync),
        .sec        (egr_sec),
        .ns         (egr_ns),
        .we_lo      (do_write && aw_idx_q == `PTP1_IDX_SYNC_LO),
        .we_hi      (do_write && aw_idx_q == `PTP1_IDX_SYNC_HI),
        .wdata      (w_data_q),
        .wstrb      (w_strb_q),
        .stamp_lo_q (sync_lo),
        .stamp_hi_q (sync_hi)
    );

    ptp1_stamp_pair u_presp (
        .aclk       (aclk),
        .aresetn    (aresetn),
        .cap        (cap_presp),
        .sec        (egr_sec),
        .ns         (egr_ns),
        .we_lo      (do_write && aw_idx_q == `PTP1_IDX_PRESP_LO),
        .we_hi      (do_write && aw_idx_q == `PTP1_IDX_PRESP_HI),
        .wdata      (w_data_q),
        .wstrb      (w_strb_q),
        .stamp_lo_q (presp_lo),
        .stamp_hi_q (presp_hi)
    );

    // ======================================================================
    // Correction field adjustment
    ptp1_corr_adjust u_corr (
        .aclk        (aclk),
        .aresetn     (aresetn),
        .asym        (asymmetry_q),
        .in_valid    (corr_valid),
        .in_ingress  (corr_ingress),
        .in_msg_type (corr_msg_type),
        .in_corr     (corr_in),
        .out_valid_q (corr_out_valid),
        .out_corr_q  (corr_out)
    );

    // ======================================================================
    // Read path
    always @* begin
        case (ar_idx)
            `PTP1_IDX_RX_LAT:   rd_mux = rx_latency_q;
            `PTP1_IDX_TX_LAT:   rd_mux = tx_latency_q;
            `PTP1_IDX_ASYM:     rd_mux = asymmetry_q;
            `PTP1_IDX_LINK_DLY: rd_mux = link_delay_q;
            `PTP1_IDX_DREQ_LO:  rd_mux = dreq_lo;
            `PTP1_IDX_DREQ_HI:  rd_mux = dreq_hi;
            `PTP1_IDX_SYNC_LO:  rd_mux = sync_lo;
            `PTP1_IDX_SYNC_HI:  rd_mux = sync_hi;
            `PTP1_IDX_PRESP_LO: rd_mux = presp_lo;
            `PTP1_IDX_PRESP_HI: rd_mux = presp_hi;
            default:            rd_mux = 16'h0000;
        endcase
    end

    // Low and high stamp words are separate reads; a capture between them tears the pair
    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h00000000;
            s_axi_rresp   <= `PTP1_RESP_OKAY;
        end else begin
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_arready <= 1'b0;
                s_axi_rvalid  <= 1'b1;
                s_axi_rdata   <= {16'h0000, rd_mux};
                s_axi_rresp   <= mapped(ar_idx) ? `PTP1_RESP_OKAY : `PTP1_RESP_SLVERR;
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end else if (!s_axi_rvalid && !s_axi_arready) begin
                s_axi_arready <= 1'b1;
            end
        end
    end

endmodule
`default_nettype wire

//--- verif/ptp1_regs_checker.sv
// Bus timing and correction checker for the port 1 timing registers
`default_nettype none
`include "ptp1_regs.vh"

module ptp1_regs_checker (
    input wire logic        aclk,
    input wire logic        aresetn,
    input wire logic        s_axi_awvalid,
    input wire logic        s_axi_awready,
    input wire logic        s_axi_wvalid,
    input wire logic        s_axi_wready,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready,
    input wire logic [1:0]  s_axi_bresp,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic        corr_valid,
    input wire logic        corr_ingress,
    input wire logic [3:0]  corr_msg_type,
    input wire logic [63:0] corr_in,
    input wire logic        corr_out_valid,
    input wire logic [63:0] corr_out,
    input wire logic [15:0] tx_latency_q,
    input wire logic [15:0] asymmetry_q
);
// ==========================================
// Expected correction, from the register value at the request edge
logic [63:0] mag_w;
logic [63:0] adj_w;
logic [63:0] exp_q;
assign mag_w = {33'h0, asymmetry_q[14:0], 16'h0000};
assign adj_w = asymmetry_q[15] ? (64'h0 - mag_w) : mag_w;
always_ff @(posedge aclk) begin
    if (!aresetn) exp_q <= 64'h0;
    else if (corr_valid && corr_ingress && (corr_msg_type == `PTP1_MSG_SYNC || corr_msg_type == `PTP1_MSG_PDLY_RESP))
        exp_q <= corr_in + adj_w;
    else if (corr_valid && !corr_ingress && (corr_msg_type == `PTP1_MSG_DLY_REQ || corr_msg_type == `PTP1_MSG_PDLY_REQ))
        exp_q <= corr_in - adj_w;
    else if (corr_valid) exp_q <= corr_in;
end
// ==========================================
// Assertions
default clocking cb @(posedge aclk); endclocking
default disable iff (!aresetn);
a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
    else $error("write response late");
a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
a_aw_rearm: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_awready ##1 s_axi_awready)
    else $error("address slot rearm wrong");
a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
    else $error("read answer late");
a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
a_rdata_upper: assert property (s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0000)
    else $error("upper read half not zero");
a_corr_pulse: assert property (1'b1 |=> corr_out_valid == $past(corr_valid))
    else $error("correction valid timing wrong");
a_corr_value: assert property (corr_out_valid |-> corr_out == exp_q)
    else $error("correction value wrong");
a_reset_vals: assert property ($rose(aresetn) |-> tx_latency_q == 16'h002D && asymmetry_q == 16'h0000)
    else $error("reset value wrong");
endmodule

bind ptp1_timing_regs ptp1_regs_checker u_chk (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_bresp(s_axi_bresp), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata),
    .corr_valid(corr_valid), .corr_ingress(corr_ingress), .corr_msg_type(corr_msg_type),
    .corr_in(corr_in), .corr_out_valid(corr_out_valid), .corr_out(corr_out),
    .tx_latency_q(tx_latency_q), .asymmetry_q(asymmetry_q));
`default_nettype wire

//--- verif/tb.sv
// Self-checking bench for the port 1 timing registers
`default_nettype none
`include "ptp1_regs.vh"

module tb;
timeunit 1ns;
timeprecision 1ps;
// ==========================================
// Signals
logic aclk, aresetn = 1'b0, s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, egr_valid = 1'b0, corr_valid = 1'b0, corr_ingress = 1'b0;
logic [15:0] s_axi_awaddr = '0, s_axi_araddr = '0;
logic [31:0] s_axi_wdata = '0;
logic [3:0]  egr_msg_type = '0, corr_msg_type = '0;
logic [1:0]  egr_sec = '0;
logic [29:0] egr_ns = '0;
logic [29:0] v;
logic [63:0] corr_in = '0;
logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, corr_out_valid;
logic [1:0]  s_axi_bresp, s_axi_rresp;
logic [31:0] s_axi_rdata;
logic [63:0] corr_out;
logic [15:0] tx_latency_q, rx_latency_q, link_delay_q, asymmetry_q;
int failures = 0, check_count = 0, j, k;

ptp1_timing_regs DUT (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr), .s_axi_awprot(3'h0),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(4'hF), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
    .s_axi_arprot(3'h0), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .egr_valid(egr_valid), .egr_msg_type(egr_msg_type), .egr_sec(egr_sec),
    .egr_ns(egr_ns), .corr_valid(corr_valid), .corr_ingress(corr_ingress), .corr_msg_type(corr_msg_type),
    .corr_in(corr_in), .corr_out_valid(corr_out_valid), .corr_out(corr_out), .tx_latency_q(tx_latency_q),
    .rx_latency_q(rx_latency_q), .link_delay_q(link_delay_q), .asymmetry_q(asymmetry_q));

initial begin
    aclk = 1'b0;
    forever #10 aclk = ~aclk;
end
// ==========================================
// Helpers
function automatic logic [13:0] ridx(int n);
    return 14'h0640 + 14'(2 * n);
endfunction
function automatic logic [15:0] pat(int n);
    return 16'hA5C3 ^ (16'(n) * 16'h1111);
endfunction
function automatic logic [29:0] nsv(int n);
    return 30'h15A3_C000 + 30'(n) * 30'h0111_1111;
endfunction
task summarize;
    $display("checks %0d mismatches %0d", check_count, failures);
    if (failures == 0 && check_count > 0)
        $display("Testbench passed");
    else
        $display("Testbench failed");
    $finish;
endtask
task chk(input string nm, input logic [63:0] e, input logic [63:0] g);
    check_count++;
    if (g !== e) begin
        failures++;
        $display("mismatch %s expected %h seen %h", nm, e, g);
    end
endtask
task tmo;
    failures++;
    $display("mismatch bus answer expected within 50 cycles seen none");
    summarize;
endtask
// Master holds each request until its own ready edge
task wr(input logic [13:0] i, input logic [15:0] d, input logic [1:0] er);
    int n;
    bit a, w;
    a = 0;
    w = 0;
    @(posedge aclk);
    s_axi_awaddr <= {i, 2'b00};
    s_axi_wdata <= {16'h0000, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (n = 0; n < 50 && !s_axi_bvalid; n++) begin
        @(posedge aclk);
        if (!a && s_axi_awready) s_axi_awvalid <= 1'b0;
        if (!w && s_axi_wready) s_axi_wvalid <= 1'b0;
        a = a | s_axi_awready;
        w = w | s_axi_wready;
    end
    s_axi_bready <= 1'b0;
    if (n == 50) tmo;
    chk("bresp", er, s_axi_bresp);
endtask
task rd(input logic [13:0] i, input logic [15:0] e, input logic [1:0] er);
    int n;
    @(posedge aclk);
    s_axi_araddr <= {i, 2'b00};
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (n = 0; n < 50 && !s_axi_rvalid; n++) begin
        @(posedge aclk);
        if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
    end
    s_axi_rready <= 1'b0;
    if (n == 50) tmo;
    chk("rdata", {16'h0000, e}, s_axi_rdata);
    chk("rresp", er, s_axi_rresp);
endtask
// Leaves egr_valid high so captures can run back to back
task cap(input logic [3:0] t, input logic [1:0] s, input logic [29:0] v);
    @(posedge aclk);
    egr_valid <= 1'b1;
    egr_msg_type <= t;
    egr_sec <= s;
    egr_ns <= v;
endtask
task corr(input logic ing, input logic [3:0] t, input logic [63:0] v, input logic [15:0] asy);
    logic [63:0] a, e;
    a = {33'h0, asy[14:0], 16'h0000};
    if (asy[15]) a = 64'h0 - a;
    e = v;
    if (ing && (t == `PTP1_MSG_SYNC || t == `PTP1_MSG_PDLY_RESP)) e = v + a;
    if (!ing && (t == `PTP1_MSG_DLY_REQ || t == `PTP1_MSG_PDLY_REQ)) e = v - a;
    @(posedge aclk);
    corr_valid <= 1'b1;
    corr_ingress <= ing;
    corr_msg_type <= t;
    corr_in <= v;
    @(posedge aclk);
    corr_valid <= 1'b0;
    @(posedge aclk);
    chk("corr_out_valid", 64'h1, corr_out_valid);
    chk("corr_out", e, corr_out);
endtask
// ==========================================
// Main sequence
initial begin
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    for (j = 0; j < 10; j++) rd(ridx(j), j == 0 ? 16'h019F : j == 1 ? 16'h002D : 16'h0000, `PTP1_RESP_OKAY);
    $display("test reset values done");
    for (j = 0; j < 10; j++) wr(ridx(j), pat(j), `PTP1_RESP_OKAY);
    for (j = 0; j < 10; j++) rd(ridx(j), pat(j), `PTP1_RESP_OKAY);
    chk("tx_latency_q", pat(1), tx_latency_q);
    chk("asymmetry_q", pat(2), asymmetry_q);
    chk("link_delay_q", pat(3), link_delay_q);
    chk("rx_latency_q", pat(0), rx_latency_q);
    $display("test read write done");
    wr(14'h0654, 16'hFFFF, `PTP1_RESP_SLVERR);
    rd(14'h0654, 16'h0000, `PTP1_RESP_SLVERR);
    rd(ridx(9), pat(9), `PTP1_RESP_OKAY);
    $display("test unmapped done");
    // Two request types share a pair, so the second must win
    cap(`PTP1_MSG_DLY_REQ, 2'(1), nsv(0));
    cap(`PTP1_MSG_PDLY_REQ, 2'(2), nsv(1));
    cap(`PTP1_MSG_SYNC, 2'(3), nsv(2));
    cap(`PTP1_MSG_PDLY_RESP, 2'(0), nsv(3));
    cap(4'h4, 2'h3, 30'h3FFF_FFFF);
    @(posedge aclk);
    egr_valid <= 1'b0;
    for (k = 1; k < 4; k++) begin
        v = nsv(k);
        rd(ridx(2 * k + 2), v[15:0], `PTP1_RESP_OKAY);
        rd(ridx(2 * k + 3), {2'(k + 1), v[29:16]}, `PTP1_RESP_OKAY);
    end
    $display("test capture done");
    for (k = 0; k < 2; k++) begin
        wr(ridx(2), k ? 16'h8123 : 16'h0123, `PTP1_RESP_OKAY);
        for (j = 0; j < 10; j++) corr(j[0], 4'(j / 2), 64'h0000_0100_0000_0000, k ? 16'h8123 : 16'h0123);
    end
    $display("test correction done");
    @(posedge aclk);
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    chk("tx_latency_q", 16'h002D, tx_latency_q);
    rd(ridx(3), 16'h0000, `PTP1_RESP_OKAY);
    $display("test second reset done");
    summarize;
end
endmodule
`default_nettype wire
